// [logic/rbs_sequencer.sv]
// reset and brown-out sequencer with its control register
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module rbs_sequencer
  import rbs_pkg::*;
#(
  parameter int POWER_UP_DELAY_TIMER_TICKS    = POWER_UP_DELAY_TIMER_TICKS_DEF,
  parameter int FILTER_CYCLES = FILTER_CYCLES_DEF
) (
  // clock, reset, enable
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // analogue supply detectors
  input  wire logic              por_supply_ok,
  input  wire logic              brownout_below,
  input  wire logic              brownout_ready_in,
  input  wire logic              low_power_brownout,
  // configuration
  input  wire logic [1:0]        brownout_mode_select,
  input  wire logic              power_up_timer_enable_n,
  input  wire logic              ext_reset_enable,
  // pin and slow oscillator
  input  wire logic              external_reset_pin_n,
  input  wire logic              low_freq_internal_osc_tick,
  // other reset sources
  input  wire logic              watchdog_reset,
  input  wire logic              reset_instruction,
  input  wire logic              stack_overflow,
  input  wire logic              stack_underflow,
  input  wire logic              prog_mode_exit,
  // core side
  input  wire logic              core_sleep,
  output logic                   core_reset,
  output logic                   wake_allowed,
  // analogue controls and events
  output logic                   brownout_detector_on,
  output logic                   bandgap_force_on,
  output logic                   brownout_reset_pulse,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata
);

  localparam int TMR_W = $clog2(POWER_UP_DELAY_TIMER_TICKS + 1);
  localparam int FLT_W = $clog2(FILTER_CYCLES + 1);
  localparam int DLY_W = $clog2(PIN_DELAY_CYCLES + 1);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(POWER_UP_DELAY_TIMER_TICKS - 1);
  localparam logic [FLT_W-1:0] FLT_MAX  = FLT_W'(FILTER_CYCLES);
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(PIN_DELAY_CYCLES - 1);

  typedef enum logic [2:0] {
    SQ_HOLD,
    SQ_TIMER,
    SQ_PIN,
    SQ_DELAY,
    SQ_BORWAIT,
    SQ_RUN
  } rbs_state_e;

  typedef struct packed {
    rbs_state_e       st;
    logic [TMR_W-1:0] tmr;
    logic [FLT_W-1:0] flt;
    logic [DLY_W-1:0] dly;
    logic             sw_en;
    logic             fast;
    logic [7:0]       rdata;
    logic             trip;
    logic             det;
    logic             bg;
    logic             rst;
  } rbs_regs_s;

  rbs_regs_s q_reg;
  rbs_regs_s q_next;

  // detection on per mode; sleep only matters in mode 10
  function automatic logic rbs_active(input logic [1:0] mode,
                                      input logic sw, input logic slp);
    unique case (mode)
      MODE_ON:       rbs_active = 1'b1;
      MODE_SLEEPOFF: rbs_active = !slp;
      MODE_SW:       rbs_active = sw;
      MODE_OFF:      rbs_active = 1'b0;
    endcase
  endfunction : rbs_active

  // start-up waits for the detector only where the mode forces it on
  function automatic logic rbs_waits(input logic [1:0] mode);
    rbs_waits = (mode == MODE_ON) || (mode == MODE_SLEEPOFF);
  endfunction : rbs_waits

  logic bo_active;
  logic bo_ready;
  logic bo_protect;
  logic trip_now;
  logic cold_src;
  logic warm_src;
  logic addr_hit;
  logic pin_low;
  logic start_ok;
  rbs_state_e after_timer;

  // mode decode shared by status, protection and start gating
  assign bo_active  = rbs_active(brownout_mode_select, q_reg.sw_en, core_sleep);
  assign bo_ready   = bo_active && brownout_ready_in;
  assign bo_protect = bo_ready;
  assign addr_hit   = (reg_addr == REG_BO_CTRL);
  assign pin_low    = ext_reset_enable && !external_reset_pin_n;
  // a dip counts only once it outlasts the filter
  assign trip_now   = bo_protect && brownout_below && (q_reg.flt == FLT_MAX);
  // cold sources restart the whole sequence, timer included
  assign cold_src   = !por_supply_ok || trip_now || low_power_brownout
                      || prog_mode_exit;
  // warm sources reset the core but skip the power-up timer
  assign warm_src   = pin_low || watchdog_reset || reset_instruction
                      || stack_overflow || stack_underflow;
  assign start_ok   = !rbs_waits(brownout_mode_select)
                      || (brownout_ready_in && !brownout_below);
  assign after_timer = pin_low ? SQ_PIN : SQ_BORWAIT;

  // next-state logic for the whole block
  always_comb begin
    q_next      = q_reg;
    q_next.trip = 1'b0;
    q_next.rdata = 8'h00;
    // software writes; both bits store in every mode
    if (reg_wr && addr_hit) begin
      q_next.sw_en = reg_wdata[SW_EN_BIT];
      q_next.fast  = reg_wdata[FAST_BIT];
    end
    // read data stand only in the cycle after the strobe
    if (reg_rd && addr_hit) begin
      q_next.rdata[SW_EN_BIT] = q_reg.sw_en;
      q_next.rdata[FAST_BIT]  = q_reg.fast;
      q_next.rdata[READY_BIT] = bo_ready;
    end
    // noise filter: count cycles below threshold, clear on recovery
    if (bo_protect && brownout_below) begin
      if (q_reg.flt != FLT_MAX) begin
        q_next.flt = q_reg.flt + FLT_W'(1);
      end
    end else begin
      q_next.flt = '0;
    end
    // sequencer
    unique case (q_reg.st)
      SQ_HOLD: begin
        q_next.tmr = '0;
        if (por_supply_ok && !(bo_protect && brownout_below)) begin
          q_next.st = power_up_timer_enable_n ? after_timer : SQ_TIMER;
        end
      end
      SQ_TIMER: begin
        // runs regardless of the pin, one step per slow tick
        if (low_freq_internal_osc_tick) begin
          if (q_reg.tmr == TMR_LAST) begin
            q_next.st = after_timer;
          end else begin
            q_next.tmr = q_reg.tmr + TMR_W'(1);
          end
        end
      end
      SQ_PIN: begin
        if (!pin_low) begin
          q_next.dly = '0;
          q_next.st  = SQ_DELAY;
        end
      end
      SQ_DELAY: begin
        if (q_reg.dly == DLY_LAST) begin
          q_next.st = SQ_BORWAIT;
        end else begin
          q_next.dly = q_reg.dly + DLY_W'(1);
        end
      end
      SQ_BORWAIT: begin
        if (start_ok) begin
          q_next.st = SQ_RUN;
        end
      end
      SQ_RUN: begin
        q_next.st = q_reg.st;
      end
    endcase
    // warm resets do not disturb a running power-up timer
    if (warm_src && q_reg.st != SQ_HOLD && q_reg.st != SQ_TIMER) begin
      q_next.st = SQ_PIN;
    end
    // cold resets win over everything
    if (cold_src) begin
      q_next.st = SQ_HOLD;
    end
    q_next.trip = trip_now;
    q_next.det  = bo_active;
    q_next.bg   = q_reg.fast && (brownout_mode_select == MODE_SLEEPOFF
                  || brownout_mode_select == MODE_SW);
    q_next.rst  = (q_next.st != SQ_RUN);
  end

  // state register; clock enable freezes everything
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q_reg       <= '0;
      q_reg.st    <= SQ_HOLD;
      q_reg.sw_en <= SW_EN_RST;
      q_reg.fast  <= FAST_RST;
      q_reg.rst   <= 1'b1;
    end else if (clk_en) begin
      q_reg <= q_next;
    end
  end

  // outputs
  assign core_reset           = q_reg.rst;
  assign brownout_detector_on = q_reg.det;
  assign bandgap_force_on     = q_reg.bg;
  assign brownout_reset_pulse = q_reg.trip;
  assign reg_rdata            = q_reg.rdata;
  // only the sleep-off mode makes wake-up wait for the detector
  assign wake_allowed = (brownout_mode_select != MODE_SLEEPOFF)
                        || brownout_ready_in;

  // checks on the sequencing
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  hold_supply_a: assert property (clk_en && !por_supply_ok |=> core_reset)
    else $error("core released while supply low");

  timer_hold_a: assert property (q_reg.st == SQ_TIMER |-> core_reset)
    else $error("core released while timer counts");

  timer_end_a: assert property (q_reg.st == SQ_TIMER && q_next.st != SQ_TIMER
      && q_next.st != SQ_HOLD |-> q_reg.tmr == TMR_LAST
      && low_freq_internal_osc_tick)
    else $error("timer left before full count");

  tick_step_a: assert property (clk_en && q_reg.st == SQ_TIMER
      && !low_freq_internal_osc_tick |=> q_reg.tmr == $past(q_reg.tmr))
    else $error("timer stepped without slow tick");

  bypass_a: assert property (clk_en && q_reg.st == SQ_HOLD
      && power_up_timer_enable_n |=> q_reg.st != SQ_TIMER)
    else $error("timer ran while bypassed");

  release_a: assert property (q_reg.st == SQ_HOLD && q_next.st == SQ_TIMER
      |-> por_supply_ok && !(bo_protect && brownout_below))
    else $error("timer started before release");

  // start-up gating by mode
  bor_wait_a: assert property (clk_en && q_reg.st == SQ_BORWAIT
      && rbs_waits(brownout_mode_select) && !brownout_ready_in |=> core_reset)
    else $error("start did not wait for ready");

  start_run_a: assert property (clk_en && q_reg.st == SQ_BORWAIT
      && rbs_waits(brownout_mode_select) && brownout_ready_in && !brownout_below
      && !cold_src && !warm_src |=> !core_reset)
    else $error("forced-on start delayed");

  sw_start_a: assert property (clk_en && q_reg.st == SQ_BORWAIT
      && !rbs_waits(brownout_mode_select) && !cold_src && !warm_src
      |=> !core_reset)
    else $error("software mode start delayed");

  // brown-out filter and its trip
  filter_a: assert property ($rose(brownout_reset_pulse)
      |-> $past(brownout_below, 1) && $past(brownout_below, 2))
    else $error("trip without sustained dip");

  trip_hold_a: assert property (brownout_reset_pulse |-> core_reset)
    else $error("trip left the core running");

  // software enable and fast start
  sw_enable_a: assert property (clk_en && brownout_mode_select == MODE_SW
      && $stable(brownout_mode_select)
      |=> brownout_detector_on == $past(q_reg.sw_en))
    else $error("detector ignores software enable");

  sw_store_a: assert property (clk_en && reg_wr && addr_hit
      |=> q_reg.sw_en == $past(reg_wdata[SW_EN_BIT])
      && q_reg.fast == $past(reg_wdata[FAST_BIT]))
    else $error("control bits not stored");

  fast_none_a: assert property (clk_en && (brownout_mode_select == MODE_ON
      || brownout_mode_select == MODE_OFF) |=> !bandgap_force_on)
    else $error("fast start acted in wrong mode");

  fast_mode_a: assert property (clk_en && q_reg.fast
      && (brownout_mode_select == MODE_SLEEPOFF || brownout_mode_select == MODE_SW)
      |=> bandgap_force_on)
    else $error("fast start ignored");

  // register reads
  ready_read_a: assert property (clk_en && reg_rd && addr_hit
      |=> reg_rdata[5:1] == 5'h00 && reg_rdata[READY_BIT] == $past(bo_ready))
    else $error("control register read wrong");

  rdata_idle_a: assert property (clk_en && !(reg_rd && addr_hit)
      |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");

  // pin release delay
  // helper: cycles spent in the pin delay, kept apart from the sequencer's
  // own counter; a long hold is checked on a count, not on a repetition
  logic [DLY_W-1:0] chk_dly_cnt;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      chk_dly_cnt <= '0;
    end else if (clk_en) begin
      chk_dly_cnt <= (q_reg.st == SQ_DELAY) ? chk_dly_cnt + DLY_W'(1) : '0;
    end
  end

  pin_delay_a: assert property (clk_en && q_reg.st == SQ_DELAY
      && q_next.st == SQ_BORWAIT |-> chk_dly_cnt == DLY_LAST)
    else $error("pin release delay wrong length");

  delay_hold_a: assert property (q_reg.st == SQ_DELAY |-> core_reset)
    else $error("core released during pin delay");

  // reset sources
  warm_reset_a: assert property (clk_en && q_reg.st == SQ_RUN && (watchdog_reset
      || reset_instruction || stack_overflow || stack_underflow) |=> core_reset)
    else $error("warm source did not reset core");

  cold_reset_a: assert property (clk_en && (low_power_brownout || prog_mode_exit)
      |=> q_reg.st == SQ_HOLD && core_reset)
    else $error("cold source did not restart");

  pin_hold_a: assert property (clk_en && ext_reset_enable
      && !external_reset_pin_n |=> core_reset)
    else $error("core released while pin low");

  // sleep and wake per mode
  wake_on_a: assert property (brownout_mode_select == MODE_ON |-> wake_allowed)
    else $error("wake delayed in always-on mode");

  wake_wait_a: assert property (brownout_mode_select == MODE_SLEEPOFF
      && !brownout_ready_in |-> !wake_allowed)
    else $error("wake ahead of detector ready");

  always_on_a: assert property (clk_en && brownout_mode_select == MODE_ON
      |=> brownout_detector_on)
    else $error("detector off in always-on mode");

  sleep_off_a: assert property (clk_en && brownout_mode_select == MODE_SLEEPOFF
      && core_sleep |=> !brownout_detector_on)
    else $error("detector on while sleeping");

  off_mode_a: assert property (clk_en && brownout_mode_select == MODE_OFF
      |=> !brownout_detector_on)
    else $error("detector on in off mode");

  sleep_keep_a: assert property (clk_en && $past(clk_en)
      && brownout_mode_select == MODE_SW && $stable(brownout_mode_select)
      && $stable(q_reg.sw_en) && $changed(core_sleep)
      |=> brownout_detector_on == $past(brownout_detector_on))
    else $error("sleep changed software protection");

  // clock enable low freezes every state bit
  freeze_a: assert property (!clk_en |=> $stable(q_reg))
    else $error("state moved with clock enable low");

  run_c: cover property (q_reg.st == SQ_BORWAIT ##1 !core_reset);
  trip_c: cover property ($rose(brownout_reset_pulse));
  pin_c: cover property (q_reg.st == SQ_PIN ##1 q_reg.st == SQ_DELAY);
  write_c: cover property (reg_wr && addr_hit ##1 reg_rd && addr_hit);
  timer_c: cover property (q_reg.st == SQ_TIMER ##1 q_reg.st == SQ_PIN);

endmodule : rbs_sequencer

// [shared/rbs_pkg.sv]
// constants and register layout of the reset and brown-out sequencer
// Notes on behaviour
// - many sources each force the core reset
// - core held while supply under minimum
// - power-up timer gives nominal 64 ms
// - core held while power-up timer counts
// - timer enabled by low enable, else bypassed
// - timer starts after supply and brown-out release
// - mode 11: always on, start waits ready
// - mode 11: protection kept during sleep
// - mode 11: wake-up never delayed
// - mode 10: off in sleep, start/wake wait
// - mode 10: no protection while sleeping
// - mode 01: software enable, start never waits
// - mode 01: protects once ready, ready bit shows
// - mode 01: sleep leaves protection unchanged
// - trip only after dip outlasts filter time
// - bit 7 enables detection only in 01
// - bit 6 forces band gap in 10/01
// - bit 0 reads ready, bits 5-1 zero
// - forced-on modes ready before core release
// - power-up timer counts slow oscillator ticks
// - run after timer and pin release
// - pin held past timer: run 10 cycles later
package rbs_pkg;
  // register port
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  REG_BO_CTRL  = 4'h0;
  localparam int          SW_EN_BIT    = 7;
  localparam int          FAST_BIT     = 6;
  localparam int          READY_BIT    = 0;
  localparam logic        SW_EN_RST    = 1'h1;
  localparam logic        FAST_RST     = 1'h0;
  // brown-out mode select codes
  localparam logic [1:0]  MODE_ON      = 2'h3;
  localparam logic [1:0]  MODE_SLEEPOFF = 2'h2;
  localparam logic [1:0]  MODE_SW      = 2'h1;
  localparam logic [1:0]  MODE_OFF     = 2'h0;
  // timing
  localparam int          POWER_UP_DELAY_TIMER_TIME_MS = 64;
  localparam int          LF_OSC_HZ    = 31000;
  localparam int          POWER_UP_DELAY_TIMER_TICKS_DEF = (POWER_UP_DELAY_TIMER_TIME_MS * LF_OSC_HZ + 999) / 1000;
  localparam int          PIN_DELAY_CYCLES = 10;
  localparam int          FILTER_CYCLES_DEF = 20;
endpackage : rbs_pkg

// [sim/rbs_supply_model.sv]
// model of the supply detectors, the reset pin and the slow oscillator
`timescale 1ns/1ps
module rbs_supply_model #(
  parameter int TICK_DIV = 8
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // bench commands
  input  wire logic supply_up,
  input  wire logic dip,
  input  wire logic settled,
  input  wire logic pin_hold,
  // detector side
  output logic      por_supply_ok,
  output logic      brownout_below,
  output logic      brownout_ready_in,
  output logic      external_reset_pin_n,
  output logic      low_freq_internal_osc_tick
);
  int div;
  // a missing supply also reads as below threshold; the pin has a pull-up
  assign por_supply_ok        = supply_up;
  assign brownout_below       = dip | ~supply_up;
  assign brownout_ready_in    = settled & supply_up;
  assign external_reset_pin_n = ~pin_hold;
  // slow oscillator runs free, one tick every TICK_DIV fast cycles
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div <= 0;
      low_freq_internal_osc_tick <= 1'b0;
    end else begin
      div <= (div == TICK_DIV - 1) ? 0 : div + 1;
      low_freq_internal_osc_tick <= (div == TICK_DIV - 1);
    end
  end
endmodule : rbs_supply_model

// [sim/tb_reset_brownout_sequencer.sv]
// self-checking bench for the reset and brown-out sequencer
`timescale 1ns/1ps
module tb_reset_brownout_sequencer import rbs_pkg::*; ;
  localparam int PT = 5;
  localparam int FC = 3;
  localparam int TD = 8;
  logic              ref_clk, reset_n, supply_up, dip, settled, pin_hold, core_sleep;
  logic              reg_wr, reg_rd, por_ok, below, ready_in, pin_n, tick, power_up_delay_timer_n;
  logic              core_reset, wake_allowed, det_on, bg_on, bo_pulse, ce, pin_en;
  logic [1:0]        mode;
  logic [5:0]        src;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0]        reg_wdata, reg_rdata, d, e;
  int                errors, checks_done, pulses, n;

  rbs_supply_model #(.TICK_DIV(TD)) i_model (.ref_clk(ref_clk), .reset_n(reset_n),
    .supply_up(supply_up), .dip(dip), .settled(settled), .pin_hold(pin_hold),
    .por_supply_ok(por_ok), .brownout_below(below), .brownout_ready_in(ready_in),
    .external_reset_pin_n(pin_n), .low_freq_internal_osc_tick(tick));

  rbs_sequencer #(.POWER_UP_DELAY_TIMER_TICKS(PT), .FILTER_CYCLES(FC)) i_dut (.ref_clk(ref_clk),
    .reset_n(reset_n), .clk_en(ce), .por_supply_ok(por_ok), .brownout_below(below),
    .brownout_ready_in(ready_in), .low_power_brownout(src[5]),
    .brownout_mode_select(mode), .power_up_timer_enable_n(power_up_delay_timer_n),
    .ext_reset_enable(pin_en), .external_reset_pin_n(pin_n),
    .low_freq_internal_osc_tick(tick), .watchdog_reset(src[0]),
    .reset_instruction(src[1]), .stack_overflow(src[2]), .stack_underflow(src[3]),
    .prog_mode_exit(src[4]), .core_sleep(core_sleep), .core_reset(core_reset),
    .wake_allowed(wake_allowed), .brownout_detector_on(det_on),
    .bandgap_force_on(bg_on), .brownout_reset_pulse(bo_pulse), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // the trip output stays high for as long as the dip outlasts the filter, so count it at every edge
  always @(posedge ref_clk) begin
    if (bo_pulse === 1'b1) pulses++;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic restart(input logic [1:0] m, input logic tn);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    mode <= m;
    power_up_delay_timer_n <= tn;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask : restart

  // bounded wait for release of the core
  task automatic run_time(output int k);
    k = 0;
    while (core_reset !== 1'b0 && k < 500) begin
      cyc(1);
      k++;
    end
  endtask : run_time

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // watchdog, far beyond the few hundred cycles the tests take
  initial begin
    #200000;
    errors++;
    wrap_up();
  end

  initial begin
    {reset_n, dip, pin_hold, core_sleep, reg_wr, reg_rd, mode, src} = '0;
    {supply_up, settled, power_up_delay_timer_n, ce, pin_en} = 5'h1F;
    {reg_addr, reg_wdata} = '0;
    {errors, checks_done, pulses} = '0;
    void'($urandom(14));
    restart(2'h0, 1'b1);
    run_time(n);
    check(n <= 4, 1);
    rd(REG_BO_CTRL, d);
    check(d & 8'hFE, 8'h80);
    supply_up <= 1'b0;
    restart(2'h0, 1'b0);
    cyc(60);
    check(core_reset, 1);
    supply_up <= 1'b1;
    run_time(n);
    check(n >= (PT - 1) * TD && n <= PT * TD + 8, 1);
    $display("test start-up done");
    settled <= 1'b0;
    restart(2'h3, 1'b1);
    cyc(40);
    check(core_reset, 1);
    settled <= 1'b1;
    run_time(n);
    check(n <= 4, 1);
    rd(REG_BO_CTRL, d);
    check(d, 8'h81);
    pulses = 0;
    dip <= 1'b1;
    cyc(FC);
    dip <= 1'b0;
    cyc(4);
    check(pulses == 0 && core_reset == 0, 1);
    dip <= 1'b1;
    cyc(FC + 3);
    check(pulses != 0 && core_reset == 1, 1);
    dip <= 1'b0;
    run_time(n);
    core_sleep <= 1'b1;
    cyc(3);
    check({det_on, wake_allowed}, 8'h03);
    mode <= 2'h2;
    settled <= 1'b0;
    cyc(3);
    check({det_on, wake_allowed}, 8'h00);
    {settled, core_sleep} <= 2'b10;
    cyc(3);
    check(det_on, 1);
    $display("test modes 11 and 10 done");
    settled <= 1'b0;
    restart(2'h1, 1'b1);
    run_time(n);
    check(n <= 4, 1);
    settled <= 1'b1;
    wr(REG_BO_CTRL, 8'h00);
    cyc(3);
    check(det_on, 0);
    wr(REG_BO_CTRL, 8'h80);
    cyc(3);
    check(det_on, 1);
    core_sleep <= 1'b1;
    cyc(3);
    check(det_on, 1);
    core_sleep <= 1'b0;
    wr(REG_BO_CTRL, 8'hC0);
    for (int m = 0; m < 4; m++) begin
      mode <= m[1:0];
      cyc(3);
      check(bg_on, m == 1 || m == 2);
    end
    // random register traffic; bit 0 follows the circuit, not the write
    repeat (6) begin
      d = 8'($urandom);
      wr(REG_BO_CTRL, d);
      rd(REG_BO_CTRL, e);
      check(e & 8'hFE, d & 8'hC0);
    end
    rd(4'($urandom_range(15, 1)), e);
    check(e, 8'h00);
    // with the clock enable low a write must not land
    ce <= 1'b0;
    wr(REG_BO_CTRL, 8'h00);
    ce <= 1'b1;
    rd(REG_BO_CTRL, e);
    check(e & 8'hC0, d & 8'hC0);
    $display("test register done");
    pin_hold <= 1'b1;
    restart(2'h0, 1'b0);
    cyc(80);
    check(core_reset, 1);
    pin_hold <= 1'b0;
    run_time(n);
    check(n >= 10 && n <= 14, 1);
    for (int i = 0; i < 6; i++) begin
      src <= 6'h01 << i;
      cyc(1);
      src <= 6'h00;
      cyc(1);
      check(core_reset, 1);
      run_time(n);
      check(n < 60, 1);
    end
    // a disabled pin function ignores the pin, an enabled one resets the core
    pin_en <= 1'b0;
    pin_hold <= 1'b1;
    cyc(20);
    check(core_reset, 0);
    pin_en <= 1'b1;
    cyc(2);
    check(core_reset, 1);
    pin_hold <= 1'b0;
    run_time(n);
    check(n >= 10 && n <= 14, 1);
    $display("test pin and sources done");
    wrap_up();
  end
endmodule : tb_reset_brownout_sequencer
